// ==== hcp_pkg.sv ====
// constants for the host command protocol engine
// assumes one 25 MHz clock; host strobes are synchronous one-cycle pulses
package hcp_pkg;
  localparam logic [7:0] CMD_READ = 8'h80;
  localparam logic [7:0] CMD_WRITE = 8'h81;
  localparam logic [7:0] CMD_BURST_ON = 8'h82;
  localparam logic [7:0] CMD_BURST_OFF = 8'h83;
  localparam logic [7:0] CMD_QUERY = 8'h84;
  // management set mirrors the os set at these codes
  localparam logic [7:0] CMD_M_READ = 8'h88;
  localparam logic [7:0] CMD_M_WRITE = 8'h89;
  localparam logic [7:0] CMD_M_BURST_ON = 8'h8a;
  localparam logic [7:0] CMD_M_BURST_OFF = 8'h8b;
  localparam logic [7:0] CMD_M_QUERY = 8'h8c;
  localparam logic [7:0] BURST_ACK = 8'h90;
  localparam logic [7:0] NO_EVENT = 8'h00;
  localparam int CLK_MHZ = 25;
  localparam int FIRST_US = 400;
  localparam int NEXT_US = 50;
  localparam int TOTAL_US = 1000;
  localparam int FIRST_CYC = FIRST_US * CLK_MHZ;
  localparam int NEXT_CYC = NEXT_US * CLK_MHZ;
  localparam int TOTAL_CYC = TOTAL_US * CLK_MHZ;
  localparam int PULSE_CYC = 4;
endpackage

// ==== hcp_evq.sv ====
`timescale 1ns/1ns
// notification queue of event codes for one environment
// assumes push of zero codes is filtered by the caller
module hcp_evq #(
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic push,
  input wire logic [7:0] push_code,
  input wire logic pop,
  output logic [7:0] head,
  output logic not_empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0] mem_r [DEPTH];
  logic [AW:0] cnt_r;
  logic [AW-1:0] rd_r;
  logic [AW-1:0] wr_r;
  logic do_push;
  logic do_pop;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("queue depth must be a power of two, at least 2");
  end

  assign do_pop = pop && cnt_r != '0;
  assign do_push = push && (cnt_r != (AW+1)'(DEPTH) || do_pop);
  assign head = cnt_r != '0 ? mem_r[rd_r] : 8'h00;
  assign not_empty = cnt_r != '0;
  assign full = cnt_r == (AW+1)'(DEPTH);

  always_ff @(posedge clk) begin
    if (do_push)
      mem_r[wr_r] <= push_code;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      rd_r <= '0;
      wr_r <= '0;
    end else begin
      if (do_push)
        wr_r <= wr_r + 1'b1;
      if (do_pop)
        rd_r <= rd_r + 1'b1;
      if (do_push && !do_pop)
        cnt_r <= cnt_r + 1'b1;
      else if (do_pop && !do_push)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

// ==== hcp_engine.sv ====
`timescale 1ns/1ns
// command protocol engine: host command/data ports, controller space,
// burst mode, os and management notification queues, pulsed interrupts
// assumes host strobes are one-cycle pulses synchronous to CLK_SYS
module hcp_engine
  import hcp_pkg::*;
#(
  parameter int AW = 8,
  parameter int QDEPTH = 8,
  parameter int FIRST_CYCLES = FIRST_CYC,
  parameter int NEXT_CYCLES = NEXT_CYC,
  parameter int TOTAL_CYCLES = TOTAL_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CMD_WR,
  input wire logic DATA_WR,
  input wire logic [7:0] HOST_WDATA,
  input wire logic DATA_RD,
  output logic [7:0] DATA_PORT_OUT,
  output logic INPUT_FULL_FLAG,
  output logic OUTPUT_FULL_FLAG,
  output logic CMD_FLAG,
  output logic BURST_FLAG,
  output logic OS_EVENT_PENDING,
  output logic MGMT_EVENT_PENDING,
  output logic OS_EVENT_INTERRUPT,
  output logic MGMT_INTERRUPT,
  input wire logic OS_EVENT_REQ,
  input wire logic [7:0] OS_EVENT_CODE,
  input wire logic MGMT_EVENT_REQ,
  input wire logic [7:0] MGMT_EVENT_CODE,
  input wire logic CRITICAL_EVENT,
  output logic OS_QUEUE_FULL,
  output logic MGMT_QUEUE_FULL
);
  import hcp_pkg::*;

  typedef enum {
    ST_IDLE, ST_RD_ADDR, ST_WR_ADDR, ST_WR_DATA, ST_OUT_WAIT
  } hcp_state_e;

  localparam int TW = $clog2(TOTAL_CYCLES + 1) + 1;

  initial begin
    if (AW < 1 || AW > 8)
      $error("address width must be 1 to 8");
    if (NEXT_CYCLES < 1 || FIRST_CYCLES < NEXT_CYCLES ||
        TOTAL_CYCLES < FIRST_CYCLES)
      $error("burst timeout counts out of order");
  end

  hcp_state_e state_r;
  logic [7:0] in_r;
  logic ibf_r, obf_r, cmd_r;
  logic [7:0] out_r;
  logic [7:0] space_r [2**AW];
  logic [AW-1:0] addr_r;
  logic mgmt_owner_r;
  logic burst_r;
  logic burst_seen_r;
  logic [TW-1:0] gap_r;
  logic [TW-1:0] total_r;
  logic [2:0] os_pulse_r, mg_pulse_r;
  logic os_int_r, mg_int_r;
  logic os_pend_r, mg_pend_r;
  logic os_q_pop, mg_q_pop;
  logic [7:0] os_head, mg_head;
  logic os_ne, mg_ne, os_full, mg_full;

  // controller consumes the input byte in the cycle after it lands
  logic take;
  logic [7:0] op;
  logic is_mgmt_cmd;
  logic fire_os, fire_mg;
  logic ie_irq, of_irq, burst_drop;
  logic [7:0] out_nxt;
  logic out_load;
  logic [2:0] op_kind;

  assign take = ibf_r && !(obf_r && state_r == ST_OUT_WAIT);
  assign op = {in_r[7:4], 1'b0, in_r[2:0]};
  assign is_mgmt_cmd = in_r[3];

  hcp_evq #(.DEPTH(QDEPTH)) u_os_q (
    .clk(CLK_SYS),
    .rst(RST),
    .push(OS_EVENT_REQ && OS_EVENT_CODE != NO_EVENT),
    .push_code(OS_EVENT_CODE),
    .pop(os_q_pop),
    .head(os_head),
    .not_empty(os_ne),
    .full(os_full)
  );

  hcp_evq #(.DEPTH(QDEPTH)) u_mg_q (
    .clk(CLK_SYS),
    .rst(RST),
    .push(MGMT_EVENT_REQ && MGMT_EVENT_CODE != NO_EVENT),
    .push_code(MGMT_EVENT_CODE),
    .pop(mg_q_pop),
    .head(mg_head),
    .not_empty(mg_ne),
    .full(mg_full)
  );

  // decode of the consumed byte: which flags change and who hears it
  always_comb begin
    ie_irq = 1'b0;
    of_irq = 1'b0;
    out_load = 1'b0;
    out_nxt = out_r;
    os_q_pop = 1'b0;
    mg_q_pop = 1'b0;
    op_kind = 3'd0;
    if (take && cmd_r) begin
      unique case (op)
        CMD_READ: ie_irq = 1'b1;
        CMD_WRITE: ie_irq = 1'b1;
        CMD_BURST_ON: begin
          out_load = 1'b1;
          out_nxt = BURST_ACK;
          of_irq = 1'b1;
        end
        CMD_BURST_OFF: begin
          ie_irq = 1'b1;
          op_kind = 3'd1;
        end
        CMD_QUERY: begin
          // code only leaves the queue on a query
          out_load = 1'b1;
          of_irq = 1'b1;
          if (is_mgmt_cmd) begin
            out_nxt = mg_ne ? mg_head : NO_EVENT;
            mg_q_pop = mg_ne;
          end else begin
            out_nxt = os_ne ? os_head : NO_EVENT;
            os_q_pop = os_ne;
          end
        end
        default: ie_irq = 1'b1;
      endcase
    end else if (take) begin
      unique case (state_r)
        ST_RD_ADDR: begin
          out_load = 1'b1;
          out_nxt = space_r[in_r[AW-1:0]];
          of_irq = 1'b1;
        end
        ST_WR_ADDR, ST_WR_DATA: ie_irq = 1'b1;
        default: ie_irq = 1'b1;
      endcase
    end
  end

  // host port side: input latch, command flag, output buffer
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      in_r <= 8'h00;
      ibf_r <= 1'b0;
      cmd_r <= 1'b0;
    end else if (CMD_WR || DATA_WR) begin
      in_r <= HOST_WDATA;
      ibf_r <= 1'b1;
      cmd_r <= CMD_WR;
    end else if (take) begin
      ibf_r <= 1'b0;
    end
  end

  // a host read and a new load in one cycle: the load wins, output stays full
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      out_r <= 8'h00;
      obf_r <= 1'b0;
    end else if (out_load) begin
      out_r <= out_nxt;
      obf_r <= 1'b1;
    end else if (DATA_RD) begin
      obf_r <= 1'b0;
    end
  end

  // command sequencer
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_r <= ST_IDLE;
      addr_r <= '0;
      mgmt_owner_r <= 1'b0;
    end else if (take) begin
      if (cmd_r) begin
        mgmt_owner_r <= is_mgmt_cmd;
        unique case (op)
          CMD_READ: state_r <= ST_RD_ADDR;
          CMD_WRITE: state_r <= ST_WR_ADDR;
          default: state_r <= ST_IDLE;
        endcase
      end else begin
        unique case (state_r)
          ST_RD_ADDR: state_r <= ST_IDLE;
          ST_WR_ADDR: begin
            addr_r <= in_r[AW-1:0];
            state_r <= ST_WR_DATA;
          end
          ST_WR_DATA: state_r <= ST_IDLE;
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (take && !cmd_r && state_r == ST_WR_DATA)
      space_r[addr_r] <= in_r;
  end

  // burst mode with its three watchdogs
  assign burst_drop = burst_r && (CRITICAL_EVENT ||
    gap_r >= TW'(burst_seen_r ? NEXT_CYCLES : FIRST_CYCLES) ||
    total_r >= TW'(TOTAL_CYCLES));

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      burst_r <= 1'b0;
      burst_seen_r <= 1'b0;
      gap_r <= '0;
      total_r <= '0;
    end else if (take && cmd_r && op == CMD_BURST_ON) begin
      burst_r <= 1'b1;
      burst_seen_r <= 1'b0;
      gap_r <= '0;
      total_r <= '0;
    end else if (op_kind == 3'd1 || burst_drop) begin
      burst_r <= 1'b0;
    end else if (burst_r) begin
      total_r <= total_r + 1'b1;
      if (CMD_WR || DATA_WR || DATA_RD) begin
        gap_r <= '0;
        burst_seen_r <= 1'b1;
      end else begin
        gap_r <= gap_r + 1'b1;
      end
    end
  end

  // pending trails the queue by one cycle so its rise can fire the interrupt
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      os_pend_r <= 1'b0;
      mg_pend_r <= 1'b0;
    end else begin
      os_pend_r <= os_ne;
      mg_pend_r <= mg_ne;
    end
  end

  // interrupt routing: burst halts new notifications reaching the host
  assign fire_os = ((ie_irq || of_irq) && !mgmt_nxt_owner()) ||
    (burst_drop && !mgmt_owner_r) ||
    (os_ne && !os_pend_r && !burst_r);
  assign fire_mg = ((ie_irq || of_irq) && mgmt_nxt_owner()) ||
    (burst_drop && mgmt_owner_r) ||
    (mg_ne && !mg_pend_r && !burst_r);

  function automatic logic mgmt_nxt_owner();
    mgmt_nxt_owner = cmd_r ? is_mgmt_cmd : mgmt_owner_r;
  endfunction

  // fixed-width pulses so an edge-sensitive input always sees one edge
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      os_pulse_r <= 3'd0;
      mg_pulse_r <= 3'd0;
      os_int_r <= 1'b0;
      mg_int_r <= 1'b0;
    end else begin
      if (fire_os && !os_int_r)
        os_pulse_r <= 3'(PULSE_CYC - 1);
      else if (os_pulse_r != 3'd0)
        os_pulse_r <= os_pulse_r - 1'b1;
      os_int_r <= (fire_os && !os_int_r) || os_pulse_r > 3'd1;
      if (fire_mg && !mg_int_r)
        mg_pulse_r <= 3'(PULSE_CYC - 1);
      else if (mg_pulse_r != 3'd0)
        mg_pulse_r <= mg_pulse_r - 1'b1;
      mg_int_r <= (fire_mg && !mg_int_r) || mg_pulse_r > 3'd1;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      DATA_PORT_OUT <= 8'h00;
      INPUT_FULL_FLAG <= 1'b0;
      OUTPUT_FULL_FLAG <= 1'b0;
      CMD_FLAG <= 1'b0;
      BURST_FLAG <= 1'b0;
      OS_EVENT_PENDING <= 1'b0;
      MGMT_EVENT_PENDING <= 1'b0;
      OS_EVENT_INTERRUPT <= 1'b0;
      MGMT_INTERRUPT <= 1'b0;
      OS_QUEUE_FULL <= 1'b0;
      MGMT_QUEUE_FULL <= 1'b0;
    end else begin
      DATA_PORT_OUT <= out_r;
      INPUT_FULL_FLAG <= ibf_r;
      OUTPUT_FULL_FLAG <= obf_r;
      CMD_FLAG <= cmd_r;
      BURST_FLAG <= burst_r;
      OS_EVENT_PENDING <= os_pend_r;
      MGMT_EVENT_PENDING <= mg_pend_r;
      OS_EVENT_INTERRUPT <= os_int_r;
      MGMT_INTERRUPT <= mg_int_r;
      OS_QUEUE_FULL <= os_full;
      MGMT_QUEUE_FULL <= mg_full;
    end
  end
endmodule

// ==== hcp_monitor.sv ====
// port-level checker for hcp_engine
// assumes a bind from the bench top and the single CLK_SYS domain
`timescale 1ns/1ns
module hcp_monitor #(
  parameter int TOTAL_CYCLES = 100
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CMD_WR,
  input wire logic DATA_WR,
  input wire logic DATA_RD,
  input wire logic CRITICAL_EVENT,
  input wire logic [7:0] DATA_PORT_OUT,
  input wire logic INPUT_FULL_FLAG,
  input wire logic OUTPUT_FULL_FLAG,
  input wire logic CMD_FLAG,
  input wire logic BURST_FLAG,
  input wire logic OS_EVENT_PENDING,
  input wire logic OS_EVENT_INTERRUPT,
  input wire logic MGMT_INTERRUPT
);
  int burst_cnt_r;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST || !BURST_FLAG) burst_cnt_r <= 0;
    else burst_cnt_r <= burst_cnt_r + 1;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  sequence s_pulse3;
    OS_EVENT_INTERRUPT [*3] ##1 !OS_EVENT_INTERRUPT;
  endsequence
  sequence s_any_irq;
    ##[0:4] (OS_EVENT_INTERRUPT || MGMT_INTERRUPT);
  endsequence
  a_cmd_latch: assert property (
    CMD_WR |-> ##2 INPUT_FULL_FLAG && CMD_FLAG)
    else $error("command byte not latched");
  a_data_latch: assert property (
    DATA_WR |-> ##2 INPUT_FULL_FLAG && !CMD_FLAG)
    else $error("data byte not latched");
  a_read_clears: assert property (
    DATA_RD && OUTPUT_FULL_FLAG |-> ##[1:2] !OUTPUT_FULL_FLAG)
    else $error("output full not cleared");
  a_obf_irq: assert property ($rose(OUTPUT_FULL_FLAG) |-> s_any_irq)
    else $error("no interrupt on output full");
  a_pulse_width: assert property ($rose(OS_EVENT_INTERRUPT) |-> s_pulse3)
    else $error("interrupt pulse width wrong");
  a_pend_irq: assert property (
    $rose(OS_EVENT_PENDING) && !BURST_FLAG |-> ##[0:4] OS_EVENT_INTERRUPT)
    else $error("no interrupt on pending event");
  a_burst_ack: assert property (
    $rose(BURST_FLAG) |-> ##[0:3] OUTPUT_FULL_FLAG && DATA_PORT_OUT == 8'h90)
    else $error("burst acknowledge missing");
  a_burst_total: assert property (
    BURST_FLAG |-> burst_cnt_r <= TOTAL_CYCLES + 8)
    else $error("burst outlived total limit");
  a_crit_exit: assert property (
    CRITICAL_EVENT && BURST_FLAG |-> ##[1:4] !BURST_FLAG)
    else $error("critical event kept burst");
  a_exit_irq: assert property ($fell(BURST_FLAG) |-> s_any_irq)
    else $error("no interrupt on burst exit");
  a_reset_clear: assert property (
    $fell(RST) |-> !INPUT_FULL_FLAG && !OUTPUT_FULL_FLAG && !BURST_FLAG)
    else $error("flags not cleared by reset");
endmodule

// ==== hcp_host.sv ====
// host processor model: port writes and data reads
// assumes strobes sampled on the rising edge of clk
`timescale 1ns/1ns
module hcp_host (
  input wire logic clk,
  input wire logic in_full,
  input wire logic out_full,
  input wire logic [7:0] dout,
  output logic cmd_wr,
  output logic data_wr,
  output logic [7:0] wdata,
  output logic data_rd
);
  initial begin
    cmd_wr = 1'b0;
    data_wr = 1'b0;
    wdata = 8'h00;
    data_rd = 1'b0;
  end
  task automatic send(input logic is_cmd, input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clk);
    wdata = b;
    cmd_wr = is_cmd;
    data_wr = !is_cmd;
    @(negedge clk);
    cmd_wr = 1'b0;
    data_wr = 1'b0;
    // bus not held after the strobe
    wdata = ~b;
    repeat (2) @(negedge clk);
    while (in_full && n < 2000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic rcv(output logic [7:0] b);
    int n;
    n = 0;
    while (!out_full && n < 2000) begin
      @(negedge clk);
      n++;
    end
    b = dout;
    data_rd = 1'b1;
    @(negedge clk);
    data_rd = 1'b0;
    repeat (2) @(negedge clk);
  endtask
endmodule

// ==== tb_host_command_protocol_engine.sv ====
// self-checking bench for hcp_engine with host model and monitor
// assumes shortened burst limits handed to the engine parameters
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb_host_command_protocol_engine;
  import hcp_pkg::*;
  localparam int FC = 60;
  localparam int NC = 20;
  localparam int TC = 200;
  logic clk, rst, cmd_wr, data_wr, data_rd, osr, mgr, crit;
  logic [7:0] wdata, dout, osc, mgc, a, d, r, md;
  logic ifl, ofl, cfl, bfl, osp, mgp, osi, mgi, os_q, mg_q, oqf, mqf;
  int mismatches, n_checks, n_os, n_mg;
  hcp_engine #(.FIRST_CYCLES(FC), .NEXT_CYCLES(NC), .TOTAL_CYCLES(TC))
  hcp_engine_inst (.CLK_SYS(clk), .RST(rst), .CMD_WR(cmd_wr),
    .DATA_WR(data_wr), .HOST_WDATA(wdata), .DATA_RD(data_rd),
    .DATA_PORT_OUT(dout), .INPUT_FULL_FLAG(ifl), .OUTPUT_FULL_FLAG(ofl),
    .CMD_FLAG(cfl), .BURST_FLAG(bfl), .OS_EVENT_PENDING(osp),
    .MGMT_EVENT_PENDING(mgp), .OS_EVENT_INTERRUPT(osi),
    .MGMT_INTERRUPT(mgi), .OS_EVENT_REQ(osr), .OS_EVENT_CODE(osc),
    .MGMT_EVENT_REQ(mgr), .MGMT_EVENT_CODE(mgc), .CRITICAL_EVENT(crit),
    .OS_QUEUE_FULL(oqf), .MGMT_QUEUE_FULL(mqf));
  hcp_host hcp_host_inst (.clk(clk), .in_full(ifl), .out_full(ofl),
    .dout(dout), .cmd_wr(cmd_wr), .data_wr(data_wr), .wdata(wdata),
    .data_rd(data_rd));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) begin
    if (osi === 1'b1 && os_q !== 1'b1) n_os++;
    if (mgi === 1'b1 && mg_q !== 1'b1) n_mg++;
    os_q = osi;
    mg_q = mgi;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c);
    hcp_host_inst.send(1'b1, c);
  endtask
  task automatic burst_in();
    cmd(CMD_BURST_ON);
    hcp_host_inst.rcv(r);
    `CHK(r, BURST_ACK)
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    conclude();
  end
  initial begin
    {rst, osr, mgr, crit, osc, mgc} = {4'h8, 8'h00, 8'h00};
    r = $urandom(32'h47558aae);
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    `CHK({ifl, ofl, cfl, bfl, osp, mgp}, 6'h00)
    for (int k = 0; k < 8; k++) begin
      md = (k % 2) ? 8'h08 : 8'h00;
      a = (k == 0) ? 8'hff : 8'($urandom);
      d = 8'($urandom);
      {n_os, n_mg} = 0;
      cmd(CMD_WRITE | md);
      hcp_host_inst.send(1'b0, a);
      hcp_host_inst.send(1'b0, d);
      repeat (8) @(negedge clk);
      `CHK(md[3] ? n_mg : n_os, 3)
      `CHK(md[3] ? n_os : n_mg, 0)
      {n_os, n_mg} = 0;
      cmd(CMD_READ | md);
      hcp_host_inst.send(1'b0, a);
      hcp_host_inst.rcv(r);
      `CHK(r, d)
      repeat (8) @(negedge clk);
      `CHK(md[3] ? n_mg : n_os, 2)
    end
    d = 8'($urandom_range(255, 1));
    a = 8'($urandom_range(255, 1));
    @(negedge clk) {osr, osc, mgr, mgc} = {1'b1, d, 1'b1, a};
    @(negedge clk) {osr, osc, mgr, mgc} = {1'b0, ~d, 1'b0, ~a};
    repeat (6) @(negedge clk);
    `CHK({osp, mgp, ofl}, 3'b110)
    cmd(CMD_WRITE);
    hcp_host_inst.send(1'b0, 8'h10);
    hcp_host_inst.send(1'b0, 8'h5a);
    cmd(CMD_M_QUERY);
    hcp_host_inst.rcv(r);
    `CHK(r, a)
    n_os = 0;
    cmd(CMD_QUERY);
    hcp_host_inst.rcv(r);
    `CHK(r, d)
    repeat (8) @(negedge clk);
    `CHK(n_os, 1)
    cmd(CMD_QUERY);
    hcp_host_inst.rcv(r);
    `CHK(r, NO_EVENT)
    n_os = 0;
    burst_in();
    `CHK(bfl, 1'b1)
    // host sequence is over before the release
    cmd(CMD_BURST_OFF);
    repeat (8) @(negedge clk);
    `CHK(bfl, 1'b0)
    `CHK(n_os, 2)
    burst_in();
    n_os = 0;
    repeat (FC + 10) @(negedge clk);
    `CHK(bfl, 1'b0)
    `CHK(n_os, 1)
    burst_in();
    @(negedge clk) crit = 1'b1;
    @(negedge clk) crit = 1'b0;
    repeat (6) @(negedge clk);
    `CHK(bfl, 1'b0)
    for (int k = 1; k <= 8; k++)
      @(negedge clk) {osr, osc, mgr, mgc} = {1'b1, 8'(k), 1'b1, 8'(k)};
    @(negedge clk) {osr, mgr} = 2'b00;
    repeat (4) @(negedge clk);
    `CHK({oqf, mqf}, 2'b11)
    cmd(CMD_QUERY);
    hcp_host_inst.rcv(r);
    `CHK(r, 8'h01)
    `CHK({oqf, mqf}, 2'b01)
    conclude();
  end
endmodule
bind hcp_engine hcp_monitor #(.TOTAL_CYCLES(TOTAL_CYCLES)) hcp_monitor_inst (
  .CLK_SYS(CLK_SYS), .RST(RST), .CMD_WR(CMD_WR), .DATA_WR(DATA_WR),
  .DATA_RD(DATA_RD), .CRITICAL_EVENT(CRITICAL_EVENT),
  .DATA_PORT_OUT(DATA_PORT_OUT), .INPUT_FULL_FLAG(INPUT_FULL_FLAG),
  .OUTPUT_FULL_FLAG(OUTPUT_FULL_FLAG), .CMD_FLAG(CMD_FLAG),
  .BURST_FLAG(BURST_FLAG), .OS_EVENT_PENDING(OS_EVENT_PENDING),
  .OS_EVENT_INTERRUPT(OS_EVENT_INTERRUPT), .MGMT_INTERRUPT(MGMT_INTERRUPT));
